// File: rtl/rfc_params.svh
// offsets, field positions, reset values for the rf frontend registers
`ifndef RFC_PARAMS_SVH
`define RFC_PARAMS_SVH
// register indices; byte address is four times the index
`define RFC_IDX_DIST    6'h28
`define RFC_IDX_ANT     6'h29
`define RFC_IDX_TX      6'h36
`define RFC_IDX_SYNC    6'h39
`define RFC_IDX_STAT    6'h3a
// disturbance_control fields
`define RFC_DC_EN       0
`define RFC_DC_LONG     1
`define RFC_DC_THR      5:2
`define RFC_DC_W        10
// antenna_switch_control fields
`define RFC_AC_MOD      1:0
`define RFC_AC_SHORT    3:2
`define RFC_AC_RDSEL    4
`define RFC_AC_RESTORE  5
`define RFC_AC_AUTO     6
`define RFC_AC_INV      7
`define RFC_AC_W        8
// transmit_control fields
`define RFC_TC_INV      0
`define RFC_TC_GAIN     1
// receiver_sync_config fields
`define RFC_SC_TYPE     9:8
`define RFC_SC_HALF     10
`define RFC_SC_NEG      11
`define RFC_SC_LEN      15:12
`define RFC_SC_PAT      31:16
// values restored by an rf configuration load, and the read data reset value
`define RFC_LOAD_PAT    16'hb24d
`define RFC_LOAD_LEN    4'hf
`define RFC_RESET_VAL   32'h0000_0000
`endif

// File: rtl/rfc_pkg.sv
// types shared by the rf frontend control block
package rfc_pkg;
  // gray along rx -> tx -> hold
  typedef enum logic [1:0] {
    RFC_ALM_RX   = 2'b00,
    RFC_ALM_TX   = 2'b01,
    RFC_ALM_HOLD = 2'b11
  } rfc_alm_t;
  typedef enum logic [1:0] {
    RFC_SRC_ZERO = 2'b00,
    RFC_SRC_ONE  = 2'b01,
    RFC_SRC_ENV  = 2'b10,
    RFC_SRC_NENV = 2'b11
  } rfc_src_t;
  typedef enum logic [1:0] {
    RFC_CLS_NONE  = 2'b00,
    RFC_CLS_NOISE = 2'b01,
    RFC_CLS_HOST  = 2'b10,
    RFC_CLS_DIST  = 2'b11
  } rfc_cls_t;
endpackage : rfc_pkg

// File: rtl/rfc_regs.sv
// rf frontend control registers with antenna, transmit, error and sync logic
// Contract
// (R01) errors on frames shorter than threshold bytes, crc excluded, are noise
// (R02) long-error bit: errors at or above threshold are never disturbance
// (R03) software should program disturbance control with 0x187
// (R04) software should use timer 1 for disturbance handling
// (R05) card mode: bit 7 inverts short while sending, unless auto switch
// (R06) bit 6 makes hardware switch antenna for active load modulation
// (R07) writing 1 to bit 5 returns active load antenna to receive config
// (R08) bit 4 selects modulation interface control in reader mode
// (R09) short source: 00 open, 01 short, 10 envelope, 11 inverted
// (R10) modulation source: 00 zero, 01 one, 10 envelope, 11 inverted
// (R11) select fields act only in card mode passive load modulation; the code also applies them in active mode without auto switch
// (R12) bit 1 switches card gain with sending instead of envelope
// (R13) bit 0 inverts the resulting transmit signal
// (R14) bits 31:16 hold the expected sync pattern
// (R15) sync length field is valid bits minus one
// (R16) bit 11: start of frame without correlation, grid on negedge
// (R17) bit 10: last sync bit is half length
// (R18) sync type 0 plain, 1 data/collision pairs, 2 byte resync
// (R19) paired mode: collision flag masks the data bit
// (R20) type-f config load sets pattern b24d and length f
// (R21) software rewrites pattern after every config load
// (R22) disturbance control bit 0 enables error handling
// (R23) reserved bits read zero, all fields reset to zero
//
// Implementation choice: the APB slave port.
`include "rfc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module rfc_regs #(
  parameter int AW = 8,
  parameter int CW = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          reader_mode,
  input  wire logic          alm_mode,
  input  wire logic          tx_active,
  input  wire logic          tx_envelope,
  input  wire logic          rx_frame_end,
  input  wire logic          rx_frame_error,
  input  wire logic [CW-1:0] rx_byte_count,
  input  wire logic          rx_sof_arm,
  input  wire logic          rx_bit_valid,
  input  wire logic          rx_bit,
  input  wire logic          rf_config_load_command,
  input  wire logic          rf_config_type_f,
  output logic               ant_short,
  output logic               ant_mod,
  output logic               tx_out,
  output logic               card_gain_mod,
  output logic               err_to_host,
  output logic               err_noise,
  output logic               err_disturbance,
  output logic               sync_found,
  output logic               sync_negedge,
  output logic               sync_last_half,
  output logic               byte_resync
);

  // a byte address maps to an index only when word aligned
  function automatic logic hit(input logic [AW-1:0] a, input logic [5:0] i);
    hit = (a[1:0] == 2'h0) && (a[AW-1:2] == (AW-2)'(i));
  endfunction : hit

  function automatic logic src_val(input logic [1:0] s, input logic env);
    case (rfc_pkg::rfc_src_t'(s))
      rfc_pkg::RFC_SRC_ZERO: src_val = 1'b0;
      rfc_pkg::RFC_SRC_ONE:  src_val = 1'b1;
      rfc_pkg::RFC_SRC_ENV:  src_val = env;
      default:               src_val = ~env;
    endcase
  endfunction : src_val

  // newest bit in sh[0]; pattern aligned so its lsb is the last sync bit
  function automatic logic sync_hit(input logic [15:0] sh,
                                    input logic [31:0] cfg,
                                    input logic [4:0]  cnt);
    logic [4:0] n;
    logic       ok;
    n  = {1'b0, cfg[`RFC_SC_LEN]} + 5'h01;
    ok = 1'b0;
    case (cfg[`RFC_SC_TYPE])
      2'h0:
      begin
        ok = (cnt >= n);
        for (int i = 0; i < 16; i++)
          if (i < int'(n) && sh[i] != cfg[16+i])
            ok = 1'b0; // [R14] [R15]
      end
      2'h1:
      begin
        // paired positions: one per two pattern bits
        n  = {2'h0, cfg[15:13]} + 5'h01;
        ok = (cnt >= n);
        for (int p = 0; p < 8; p++)
          if (p < int'(n) && !cfg[16+2*p] && sh[p] != cfg[17+2*p])
            ok = 1'b0; // [R18] [R19]
      end
      default: ok = 1'b0; // byte resync has no pattern search [R18]
    endcase
    sync_hit = ok;
  endfunction : sync_hit

  logic [`RFC_DC_W-1:0] dist_ff, nxt_dist;
  logic [`RFC_AC_W-1:0] ant_ff, nxt_ant;
  logic [1:0]           txc_ff, nxt_txc;
  logic [31:8]          sync_ff, nxt_sync;
  logic [31:0]          prdata_ff, nxt_prdata;
  logic                 pready_ff, nxt_pready;
  logic                 pslverr_ff, nxt_pslverr;
  logic                 restore_ff, nxt_restore;
  logic                 resync_ff, nxt_resync;
  logic                 wr_en, rd_setup, mapped;
  logic [31:0]          sync_word, stat_word;
  rfc_pkg::rfc_alm_t    alm_ff, nxt_alm;
  rfc_pkg::rfc_cls_t    cls_ff, nxt_cls;

  assign wr_en    = psel & penable & pready_ff & pwrite;
  assign rd_setup = psel & ~penable;
  assign mapped   = hit(paddr, `RFC_IDX_DIST) | hit(paddr, `RFC_IDX_ANT) |
                    hit(paddr, `RFC_IDX_TX) | hit(paddr, `RFC_IDX_SYNC) |
                    hit(paddr, `RFC_IDX_STAT);
  assign sync_word = {sync_ff, 8'h00};
  assign stat_word = {28'h0, cls_ff, alm_ff};

  always_comb
  begin
    nxt_dist    = dist_ff;
    nxt_ant     = ant_ff;
    nxt_txc     = txc_ff;
    nxt_sync    = sync_ff;
    nxt_prdata  = 32'h0000_0000;
    nxt_pready  = rd_setup;
    nxt_pslverr = rd_setup & ~mapped;
    nxt_restore = 1'b0;
    if (rd_setup)
    begin
      // reserved and unwritten bits read zero [R23]
      if (hit(paddr, `RFC_IDX_DIST))
        nxt_prdata = {22'h0, dist_ff};
      else if (hit(paddr, `RFC_IDX_ANT))
        nxt_prdata = {24'h0, ant_ff};
      else if (hit(paddr, `RFC_IDX_TX))
        nxt_prdata = {30'h0, txc_ff};
      else if (hit(paddr, `RFC_IDX_SYNC))
        nxt_prdata = sync_word;
      else if (hit(paddr, `RFC_IDX_STAT))
        nxt_prdata = stat_word;
    end
    // a type-f load overrides a same-cycle software write of the pattern
    if (wr_en && hit(paddr, `RFC_IDX_SYNC))
      nxt_sync = pwdata[31:8];
    if (rf_config_load_command && rf_config_type_f)
    begin
      nxt_sync[`RFC_SC_PAT] = `RFC_LOAD_PAT; // [R20]
      nxt_sync[`RFC_SC_LEN] = `RFC_LOAD_LEN; // [R20]
    end
    if (wr_en && hit(paddr, `RFC_IDX_DIST))
      nxt_dist = pwdata[`RFC_DC_W-1:0];
    if (wr_en && hit(paddr, `RFC_IDX_TX))
      nxt_txc = pwdata[1:0];
    if (wr_en && hit(paddr, `RFC_IDX_ANT))
    begin
      nxt_ant = pwdata[`RFC_AC_W-1:0];
      // restore is an action, not a stored setting
      nxt_ant[`RFC_AC_RESTORE] = 1'b0;
      nxt_restore = pwdata[`RFC_AC_RESTORE]; // [R07]
    end
    nxt_resync = (nxt_sync[`RFC_SC_TYPE] == 2'h2); // [R18]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dist_ff    <= '0; // [R23]
      ant_ff     <= '0;
      txc_ff     <= '0;
      sync_ff    <= '0;
      prdata_ff  <= `RFC_RESET_VAL;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      restore_ff <= 1'b0;
      resync_ff  <= 1'b0;
    end
    else
    begin
      dist_ff    <= nxt_dist;
      ant_ff     <= nxt_ant;
      txc_ff     <= nxt_txc;
      sync_ff    <= nxt_sync;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      restore_ff <= nxt_restore;
      resync_ff  <= nxt_resync;
    end
  end

  // antenna, transmit and error classification datapath
  logic         short_ff, nxt_short;
  logic         mod_ff, nxt_mod;
  logic         txo_ff, nxt_txo;
  logic         gain_ff, nxt_gain;
  logic         host_ff, nxt_host;
  logic         noise_ff, nxt_noise;
  logic         dist_ev_ff, nxt_dist_ev;
  logic         auto_alm;
  logic [CW-1:0] thr;

  assign auto_alm = alm_mode & ~reader_mode & ant_ff[`RFC_AC_AUTO];
  assign thr = CW'(dist_ff[`RFC_DC_THR]);

  always_comb
  begin
    nxt_alm     = alm_ff;
    nxt_short   = 1'b0;
    nxt_mod     = 1'b0;
    nxt_cls     = cls_ff;
    nxt_host    = 1'b0;
    nxt_noise   = 1'b0;
    nxt_dist_ev = 1'b0;
    // hold keeps the load engaged until software restores it
    case (alm_ff)
      rfc_pkg::RFC_ALM_RX:
        if (auto_alm && tx_active)
          nxt_alm = rfc_pkg::RFC_ALM_TX; // [R06]
      rfc_pkg::RFC_ALM_TX:
        if (!tx_active)
          nxt_alm = rfc_pkg::RFC_ALM_HOLD;
      rfc_pkg::RFC_ALM_HOLD:
        nxt_alm = rfc_pkg::RFC_ALM_HOLD;
      default:
        nxt_alm = rfc_pkg::RFC_ALM_RX;
    endcase
    if (restore_ff)
      nxt_alm = rfc_pkg::RFC_ALM_RX; // [R07]
    if (reader_mode)
    begin
      // digital logic owns the antenna in reader mode [R11]
      nxt_mod = ant_ff[`RFC_AC_RDSEL] ? tx_active : tx_envelope; // [R08]
    end
    else if (auto_alm)
    begin
      case (alm_ff)
        rfc_pkg::RFC_ALM_TX:
        begin
          nxt_short = tx_envelope; // [R06] [R11]
          nxt_mod   = ~tx_envelope;
        end
        rfc_pkg::RFC_ALM_HOLD: nxt_short = 1'b1;
        default:               nxt_short = 1'b0;
      endcase
    end
    else
    begin
      // passive, or active without auto switch, use the same fields
      nxt_short = src_val(ant_ff[`RFC_AC_SHORT], tx_envelope) ^
                  (ant_ff[`RFC_AC_INV] & tx_active); // [R09] [R05]
      nxt_mod   = src_val(ant_ff[`RFC_AC_MOD], tx_envelope); // [R10]
    end
    nxt_txo  = tx_envelope ^ txc_ff[`RFC_TC_INV]; // [R13]
    nxt_gain = (!reader_mode && txc_ff[`RFC_TC_GAIN]) ?
               tx_active : tx_envelope; // [R12]
    if (rx_frame_end && rx_frame_error)
    begin
      if (!dist_ff[`RFC_DC_EN])
        nxt_cls = rfc_pkg::RFC_CLS_HOST; // [R22]
      else if (rx_byte_count < thr)
        nxt_cls = rfc_pkg::RFC_CLS_NOISE; // [R01]
      else if (dist_ff[`RFC_DC_LONG])
        nxt_cls = rfc_pkg::RFC_CLS_HOST; // [R02]
      else
        nxt_cls = rfc_pkg::RFC_CLS_DIST;
      nxt_host    = (nxt_cls == rfc_pkg::RFC_CLS_HOST);
      nxt_noise   = (nxt_cls == rfc_pkg::RFC_CLS_NOISE);
      nxt_dist_ev = (nxt_cls == rfc_pkg::RFC_CLS_DIST);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alm_ff     <= rfc_pkg::RFC_ALM_RX;
      cls_ff     <= rfc_pkg::RFC_CLS_NONE;
      short_ff   <= 1'b0;
      mod_ff     <= 1'b0;
      txo_ff     <= 1'b0;
      gain_ff    <= 1'b0;
      host_ff    <= 1'b0;
      noise_ff   <= 1'b0;
      dist_ev_ff <= 1'b0;
    end
    else
    begin
      alm_ff     <= nxt_alm;
      cls_ff     <= nxt_cls;
      short_ff   <= nxt_short;
      mod_ff     <= nxt_mod;
      txo_ff     <= nxt_txo;
      gain_ff    <= nxt_gain;
      host_ff    <= nxt_host;
      noise_ff   <= nxt_noise;
      dist_ev_ff <= nxt_dist_ev;
    end
  end

  // sync search: armed at frame start, ends on the first hit
  logic [15:0] sh_ff, nxt_sh;
  logic [4:0]  cnt_ff, nxt_cnt;
  logic        srch_ff, nxt_srch;
  logic        found_ff, nxt_found;

  always_comb
  begin
    nxt_sh    = sh_ff;
    nxt_cnt   = cnt_ff;
    nxt_srch  = srch_ff;
    nxt_found = 1'b0;
    if (rx_sof_arm)
    begin
      nxt_sh   = 16'h0000;
      nxt_cnt  = 5'h00;
      nxt_srch = 1'b1;
    end
    else if (srch_ff && rx_bit_valid)
    begin
      nxt_sh = {sh_ff[14:0], rx_bit};
      if (cnt_ff != 5'h10)
        nxt_cnt = cnt_ff + 5'h01;
      if (sync_hit(nxt_sh, sync_word, nxt_cnt))
      begin
        nxt_found = 1'b1; // [R14]
        nxt_srch  = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_ff    <= 16'h0000;
      cnt_ff   <= 5'h00;
      srch_ff  <= 1'b0;
      found_ff <= 1'b0;
    end
    else
    begin
      sh_ff    <= nxt_sh;
      cnt_ff   <= nxt_cnt;
      srch_ff  <= nxt_srch;
      found_ff <= nxt_found;
    end
  end

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign ant_short       = short_ff;
  assign ant_mod         = mod_ff;
  assign tx_out          = txo_ff;
  assign card_gain_mod   = gain_ff;
  assign err_to_host     = host_ff;
  assign err_noise       = noise_ff;
  assign err_disturbance = dist_ev_ff;
  assign sync_found      = found_ff;
  assign sync_negedge    = sync_ff[`RFC_SC_NEG]; // [R16]
  assign sync_last_half  = sync_ff[`RFC_SC_HALF]; // [R17]
  assign byte_resync     = resync_ff; // [R18]

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  noise_short_a: assert property (rx_frame_end && rx_frame_error && // [R01]
      dist_ff[`RFC_DC_EN] && rx_byte_count < thr |=> err_noise && !err_to_host)
    else $error("short error frame not treated as noise");
  long_err_a: assert property (rx_frame_end && rx_frame_error && // [R02]
      dist_ff[1:0] == 2'h3 && rx_byte_count >= thr |=> err_to_host)
    else $error("long error frame not reported");
  disable_host_a: assert property (rx_frame_end && rx_frame_error && // [R22]
      !dist_ff[`RFC_DC_EN] |=> err_to_host && !err_disturbance)
    else $error("disabled handling did not report error");
  short_inv_a: assert property (!reader_mode && !auto_alm && // [R05]
      ant_ff[`RFC_AC_SHORT] == 2'h0 && ant_ff[`RFC_AC_INV] |=>
      ant_short == $past(tx_active))
    else $error("short inversion while sending wrong");
  restore_a: assert property (wr_en && hit(paddr, `RFC_IDX_ANT) && // [R07]
      pwdata[`RFC_AC_RESTORE] |-> ##2 alm_ff == rfc_pkg::RFC_ALM_RX)
    else $error("restore did not return to receive");
  mod_src_a: assert property (!reader_mode && !auto_alm && // [R10]
      ant_ff[`RFC_AC_MOD] == 2'h3 |=> ant_mod == !$past(tx_envelope))
    else $error("inverted envelope modulation wrong");
  tx_inv_a: assert property (txc_ff[`RFC_TC_INV] |=> // [R13]
      tx_out != $past(tx_envelope))
    else $error("transmit inversion missing");
  load_pat_a: assert property (rf_config_load_command && // [R20]
      rf_config_type_f |=> sync_ff[31:12] == 20'hb24df)
    else $error("config load did not set sync defaults");
  apb_ans_a: assert property (psel && !penable |=> // [R23]
      pready ##1 !pready or (psel && !penable))
    else $error("apb answer timing wrong");
  found_stop_a: assert property (sync_found |-> !srch_ff [*2]) // [R14]
    else $error("search continued after sync found");
  cov_dist_c: cover property (err_disturbance);
  cov_alm_c: cover property (alm_ff == rfc_pkg::RFC_ALM_HOLD ##[1:50]
      alm_ff == rfc_pkg::RFC_ALM_RX);
  cov_pair_c: cover property (sync_found && sync_ff[`RFC_SC_TYPE] == 2'h1);

endmodule : rfc_regs
`default_nettype wire

// File: tb/rfc_far_model.sv
// far-side model: transmitter status and receiver demodulator events
`timescale 1ns/1ns
`default_nettype none
module rfc_far_model (
  input  wire logic       pclk,
  output logic            tx_active,
  output logic            tx_envelope,
  output logic            rx_frame_end,
  output logic            rx_frame_error,
  output logic [7:0]      rx_byte_count,
  output logic            rx_sof_arm,
  output logic            rx_bit_valid,
  output logic            rx_bit
);
  initial
  begin
    tx_active      = 1'b0;
    tx_envelope    = 1'b0;
    rx_frame_end   = 1'b0;
    rx_frame_error = 1'b0;
    rx_byte_count  = 8'h00;
    rx_sof_arm     = 1'b0;
    rx_bit_valid   = 1'b0;
    rx_bit         = 1'b0;
  end
  task automatic set_tx(input logic act, input logic env);
    @(posedge pclk);
    tx_active   <= act;
    tx_envelope <= env;
  endtask : set_tx
  // count excludes crc bytes; unqualified lines flip so stale data never pass
  task automatic frame(input logic err, input logic [7:0] cnt);
    @(posedge pclk);
    rx_frame_end   <= 1'b1;
    rx_frame_error <= err;
    rx_byte_count  <= cnt;
    @(posedge pclk);
    rx_frame_end   <= 1'b0;
    rx_frame_error <= ~err;
    rx_byte_count  <= ~cnt;
  endtask : frame
  // oldest bit first, bit n-1 down to bit 0
  task automatic bits(input logic [15:0] v, input int n);
    @(posedge pclk);
    rx_sof_arm <= 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge pclk);
      rx_sof_arm   <= 1'b0;
      rx_bit_valid <= 1'b1;
      rx_bit       <= v[i];
    end
    @(posedge pclk);
    rx_bit_valid <= 1'b0;
    rx_bit       <= ~v[0];
  endtask : bits
endmodule : rfc_far_model
`default_nettype wire

// File: tb/tb_rfc_regs.sv
// self-checking bench for the rf frontend control registers
`include "rfc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_rfc_regs;
  localparam logic [7:0] A_DIST = {`RFC_IDX_DIST, 2'b00};
  localparam logic [7:0] A_ANT  = {`RFC_IDX_ANT, 2'b00};
  localparam logic [7:0] A_TX   = {`RFC_IDX_TX, 2'b00};
  localparam logic [7:0] A_SYNC = {`RFC_IDX_SYNC, 2'b00};
  localparam logic [7:0] A_STAT = {`RFC_IDX_STAT, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, rx_byte_count;
  logic [31:0] pwdata, prdata;
  logic        reader_mode, alm_mode, tx_active, tx_envelope;
  logic        rx_frame_end, rx_frame_error, rx_sof_arm, rx_bit_valid;
  logic        rx_bit, rf_config_load_command, rf_config_type_f;
  logic        ant_short, ant_mod, tx_out, card_gain_mod, err_to_host;
  logic        err_noise, err_disturbance, sync_found, sync_negedge;
  logic        sync_last_half, byte_resync;
  int          miscompares = 0;
  int          check_count = 0;
  int          n_host = 0, n_noise = 0, n_dist = 0, n_sync = 0;

  rfc_regs uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reader_mode(reader_mode),
    .alm_mode(alm_mode), .tx_active(tx_active), .tx_envelope(tx_envelope),
    .rx_frame_end(rx_frame_end), .rx_frame_error(rx_frame_error),
    .rx_byte_count(rx_byte_count), .rx_sof_arm(rx_sof_arm),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .rf_config_load_command(rf_config_load_command),
    .rf_config_type_f(rf_config_type_f), .ant_short(ant_short),
    .ant_mod(ant_mod), .tx_out(tx_out), .card_gain_mod(card_gain_mod),
    .err_to_host(err_to_host), .err_noise(err_noise),
    .err_disturbance(err_disturbance), .sync_found(sync_found),
    .sync_negedge(sync_negedge), .sync_last_half(sync_last_half),
    .byte_resync(byte_resync));
  rfc_far_model far (
    .pclk(pclk), .tx_active(tx_active), .tx_envelope(tx_envelope),
    .rx_frame_end(rx_frame_end), .rx_frame_error(rx_frame_error),
    .rx_byte_count(rx_byte_count), .rx_sof_arm(rx_sof_arm),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));

  always #2 pclk = ~pclk;
  // pulses last one cycle; negedge sampling keeps clear of the launch edge
  always @(negedge pclk)
  begin
    if (err_to_host === 1'b1) n_host++;
    if (err_noise === 1'b1) n_noise++;
    if (err_disturbance === 1'b1) n_dist++;
    if (sync_found === 1'b1) n_sync++;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      miscompares++;
      final_report();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, ex}, {31'h0, e});
  endtask : rd
  task automatic settle();
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  task automatic ant_chk(input logic s, input logic m);
    settle();
    chk("ant_short", {31'h0, s}, {31'h0, ant_short});
    chk("ant_mod", {31'h0, m}, {31'h0, ant_mod});
  endtask : ant_chk
  task automatic tx_chk(input logic t, input logic g);
    settle();
    chk("tx_out", {31'h0, t}, {31'h0, tx_out});
    chk("card_gain_mod", {31'h0, g}, {31'h0, card_gain_mod});
  endtask : tx_chk
  function automatic logic src(input logic [1:0] sel, input logic env);
    return (sel == 2'b10) ? env : (sel == 2'b11) ? ~env : sel[0];
  endfunction : src

  task automatic t_reset();
    rd(A_DIST, 32'h0, 1'b0);
    rd(A_ANT, 32'h0, 1'b0);
    rd(A_TX, 32'h0, 1'b0);
    rd(A_SYNC, 32'h0, 1'b0);
    rd(8'h00, 32'h0, 1'b1);
    rd(A_ANT + 8'h01, 32'h0, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_rw();
    wr(A_DIST, 32'hffff_ffff);
    rd(A_DIST, 32'h0000_03ff, 1'b0);
    wr(A_DIST, 32'h0000_0187);
    rd(A_DIST, 32'h0000_0187, 1'b0);
    wr(A_TX, 32'hffff_ffff);
    rd(A_TX, 32'h0000_0003, 1'b0);
    wr(A_ANT, 32'hffff_ffff);
    rd(A_ANT, 32'h0000_00df, 1'b0);
    wr(A_SYNC, 32'hffff_ffff);
    rd(A_SYNC, 32'hffff_ff00, 1'b0);
    wr(A_TX, 32'h0);
    $display("test readback done");
  endtask : t_rw
  task automatic t_plm();
    for (int s = 0; s < 4; s++)
      for (int v = 0; v < 2; v++)
      begin
        wr(A_ANT, {28'h0, s[1:0], ~s[1:0]});
        far.set_tx(1'b0, v[0]);
        ant_chk(src(s[1:0], v[0]), src(~s[1:0], v[0]));
      end
    $display("test passive antenna done");
  endtask : t_plm
  task automatic t_inv();
    wr(A_ANT, 32'h0000_0087);
    far.set_tx(1'b1, 1'b0);
    ant_chk(1'b0, 1'b1);
    far.set_tx(1'b0, 1'b0);
    ant_chk(1'b1, 1'b1);
    @(posedge pclk);
    reader_mode <= 1'b1;
    far.set_tx(1'b1, 1'b0);
    ant_chk(1'b0, 1'b0);
    wr(A_ANT, 32'h0000_0097);
    ant_chk(1'b0, 1'b1);
    @(posedge pclk);
    reader_mode <= 1'b0;
    $display("test invert and reader done");
  endtask : t_inv
  task automatic t_alm();
    @(posedge pclk);
    alm_mode <= 1'b1;
    wr(A_ANT, 32'h0000_0004);
    far.set_tx(1'b1, 1'b1);
    ant_chk(1'b1, 1'b0);
    far.set_tx(1'b0, 1'b1);
    wr(A_ANT, 32'h0000_00c0);
    ant_chk(1'b0, 1'b0);
    far.set_tx(1'b1, 1'b1);
    ant_chk(1'b1, 1'b0);
    far.set_tx(1'b1, 1'b0);
    ant_chk(1'b0, 1'b1);
    far.set_tx(1'b0, 1'b0);
    ant_chk(1'b1, 1'b0);
    wr(A_ANT, 32'h0000_00e0);
    ant_chk(1'b0, 1'b0);
    rd(A_ANT, 32'h0000_00c0, 1'b0);
    @(posedge pclk);
    alm_mode <= 1'b0;
    $display("test active load done");
  endtask : t_alm
  task automatic t_tx();
    wr(A_TX, 32'h1);
    far.set_tx(1'b0, 1'b1);
    tx_chk(1'b0, 1'b1);
    wr(A_TX, 32'h2);
    tx_chk(1'b1, 1'b0);
    far.set_tx(1'b1, 1'b0);
    tx_chk(1'b0, 1'b1);
    @(posedge pclk);
    reader_mode <= 1'b1;
    tx_chk(1'b0, 1'b0);
    @(posedge pclk);
    reader_mode <= 1'b0;
    $display("test transmit done");
  endtask : t_tx
  task automatic t_err();
    logic [5:0] cf [7] = '{6'h10, 6'h11, 6'h11, 6'h11, 6'h13, 6'h13, 6'h13};
    logic [7:0] cn [7] = '{8'h02, 8'h03, 8'h04, 8'h04, 8'h04, 8'h03, 8'hff};
    logic       er [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [1:0] ex [7] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h2, 2'h1, 2'h2};
    int         h, n, d;
    for (int i = 0; i < 7; i++)
    begin
      wr(A_DIST, {26'h0, cf[i]});
      h = n_host;
      n = n_noise;
      d = n_dist;
      far.frame(er[i], cn[i]);
      repeat (3) @(negedge pclk);
      chk("err_to_host", 32'(ex[i] == 2'h2), 32'(n_host - h));
      chk("err_noise", 32'(ex[i] == 2'h1), 32'(n_noise - n));
      chk("err_disturb", 32'(ex[i] == 2'h3), 32'(n_dist - d));
    end
    rd(A_STAT, 32'h0000_0008, 1'b0);
    $display("test error filter done");
  endtask : t_err
  task automatic sync_try(input logic [15:0] v, input int n, input logic e);
    int h;
    h = n_sync;
    far.bits(v, n);
    repeat (3) @(negedge pclk);
    chk("sync_found", {31'h0, e}, 32'(n_sync - h));
  endtask : sync_try
  task automatic t_sync();
    wr(A_SYNC, 32'hc35a_7000);
    sync_try(16'h005a, 8, 1'b1);
    sync_try(16'h005b, 8, 1'b0);
    wr(A_SYNC, 32'h0001_0000);
    sync_try(16'h0001, 1, 1'b1);
    sync_try(16'h0000, 1, 1'b0);
    wr(A_SYNC, 32'h0006_3100);
    sync_try(16'h0003, 2, 1'b1);
    sync_try(16'h0001, 2, 1'b1);
    sync_try(16'h0002, 2, 1'b0);
    wr(A_SYNC, 32'hc35a_7e00);
    sync_try(16'h005a, 8, 1'b0);
    settle();
    chk("sync_negedge", 32'h1, {31'h0, sync_negedge});
    chk("sync_last_half", 32'h1, {31'h0, sync_last_half});
    chk("byte_resync", 32'h1, {31'h0, byte_resync});
    $display("test sync done");
  endtask : t_sync
  task automatic t_load();
    logic [31:0] r;
    logic        e;
    wr(A_SYNC, 32'h1234_0300);
    for (int f = 0; f < 2; f++)
    begin
      @(posedge pclk);
      rf_config_type_f       <= f[0];
      rf_config_load_command <= 1'b1;
      @(posedge pclk);
      rf_config_load_command <= 1'b0;
      apb(1'b0, A_SYNC, 32'h0, r, e);
      chk("sync_fields", f ? 32'hb24d_f000 : 32'h1234_0000,
          r & 32'hffff_f000);
    end
    wr(A_SYNC, 32'h1234_0000);
    rd(A_SYNC, 32'h1234_0000, 1'b0);
    $display("test config load done");
  endtask : t_load

  initial
  begin
    pclk                   = 1'b0;
    presetn                = 1'b0;
    psel                   = 1'b0;
    penable                = 1'b0;
    pwrite                 = 1'b0;
    paddr                  = 8'h00;
    pwdata                 = 32'h0;
    reader_mode            = 1'b0;
    alm_mode               = 1'b0;
    rf_config_load_command = 1'b0;
    rf_config_type_f       = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rw();
    t_plm();
    t_inv();
    t_alm();
    t_tx();
    t_err();
    t_sync();
    t_load();
    final_report();
  end
endmodule : tb_rfc_regs
`default_nettype wire
